// ==== dbkfr_consts.vh ====
// Constants for the debug breakpoint and force reset block
// Operation
// - A 16-bit breakpoint match register holds the comparator address.
// - Register is off the memory map; only serial breakpoint commands reach it.
// - Breakpoint enable and force/tag select bits control the comparator.
// - Force reset writes accepted only from serial debug commands; others ignored.
// - Force reset register always reads back as zero in all bits.
// - Writing one to the force reset bit serially forces a full device reset.
// - With enable clear, breakpoint is off; select bit and address are ignored.
// - Select one forces background on match; zero tags opcode for queue end.
`ifndef DBKFR_CONSTS_VH
`define DBKFR_CONSTS_VH
`define DBKFR_BKPT_RESET 16'h0000
`define DBKFR_FRC_READ 8'h00
`define DBKFR_FRC_BIT 0
`define DBKFR_RST_PULSE 4'h4
`endif

// ==== dbkfr_reset_pulse.v ====
// Stretches a force reset request into a fixed-length reset pulse
`timescale 1ns/1ps
module dbkfr_reset_pulse
(
	input  wire       i_sys_clk,
	input  wire       i_rst_n,
	input  wire       i_trigger,
	output reg        o_reset_req
);
`include "dbkfr_consts.vh"
	reg [3:0] cnt_q;
	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			cnt_q       <= 4'h0;
			o_reset_req <= 1'b0;
		end
		else
		begin
			if (i_trigger)
				cnt_q <= `DBKFR_RST_PULSE;
			else if (cnt_q != 4'h0)
				cnt_q <= cnt_q - 4'h1;
			o_reset_req <= i_trigger | (cnt_q > 4'h1);
		end
	end
endmodule

// ==== dbkfr_top.v ====
// Breakpoint match register, comparator and debug force reset register
`timescale 1ns/1ps
module dbkfr_top
(
	input  wire        i_sys_clk,
	input  wire        i_rst_n,
	input  wire        i_write_breakpoint_command,
	input  wire        i_read_breakpoint_command,
	input  wire [15:0] i_bkpt_wdata,
	input  wire        i_frc_wr,
	input  wire        i_frc_wr_serial,
	input  wire        i_frc_rd,
	input  wire [7:0]  i_frc_wdata,
	input  wire        i_breakpoint_enable,
	input  wire        i_force_tag_select,
	input  wire [15:0] i_cpu_addr,
	input  wire        i_cpu_addr_valid,
	input  wire        i_opcode_fetch,
	output reg  [15:0] o_bkpt_rdata,
	output reg         o_bkpt_rvalid,
	output reg  [7:0]  o_frc_rdata,
	output reg         o_frc_rvalid,
	output reg         o_force_bgnd_req,
	output reg         o_tag_opcode,
	output reg         o_device_reset_req
);
`include "dbkfr_consts.vh"

	// ==========================================================
	// Shared functions

	// True when an enabled, valid CPU address equals the match value
	function addr_match;
		input        enable;
		input        valid;
		input [15:0] addr;
		input [15:0] match;
		begin
			addr_match = enable & valid & (addr == match);
		end
	endfunction

	// True for a serial debug write that sets the force reset bit
	function frc_request;
		input       wr;
		input       serial;
		input [7:0] wdata;
		begin
			frc_request = wr & serial & wdata[`DBKFR_FRC_BIT];
		end
	endfunction

	// ==========================================================
	// Declarations

	// Breakpoint match register, reachable only by debug commands
	reg  [15:0] breakpoint_match_address_q;
	reg  [15:0] breakpoint_match_address_d;

	// Next values of the read-back outputs
	reg  [15:0] bkpt_rdata_d;
	reg         bkpt_rvalid_d;
	reg  [7:0]  frc_rdata_d;
	reg         frc_rvalid_d;

	// Comparator results and their next values
	wire        force_hit;
	wire        tag_hit;
	reg         force_bgnd_d;
	reg         tag_opcode_d;

	// Force reset request path
	wire        frc_take;
	wire        rst_req;
	reg         device_reset_d;

	// ==========================================================
	// Breakpoint match register

	// Only the write breakpoint command loads the register
	always @*
	begin
		breakpoint_match_address_d = breakpoint_match_address_q;
		if (i_write_breakpoint_command)
			breakpoint_match_address_d = i_bkpt_wdata;
	end

	// The comparator sees a new value one cycle after the write
	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			breakpoint_match_address_q <= `DBKFR_BKPT_RESET;
		else
			breakpoint_match_address_q <= breakpoint_match_address_d;
	end

	// ==========================================================
	// Breakpoint read-back

	// Read data holds its last value between read commands
	always @*
	begin
		bkpt_rvalid_d = i_read_breakpoint_command;
		bkpt_rdata_d  = o_bkpt_rdata;
		if (i_read_breakpoint_command)
			bkpt_rdata_d = breakpoint_match_address_q;
	end

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_bkpt_rdata  <= 16'h0000;
			o_bkpt_rvalid <= 1'b0;
		end
		else
		begin
			o_bkpt_rdata  <= bkpt_rdata_d;
			o_bkpt_rvalid <= bkpt_rvalid_d;
		end
	end

	// ==========================================================
	// Comparator

	// With the enable clear, select and match value are ignored
	assign force_hit = addr_match(i_breakpoint_enable, i_cpu_addr_valid,
		i_cpu_addr, breakpoint_match_address_q) &
		i_force_tag_select;

	// Tagging only makes sense on an opcode fetch
	assign tag_hit = addr_match(i_breakpoint_enable, i_cpu_addr_valid,
		i_cpu_addr, breakpoint_match_address_q) &
		~i_force_tag_select & i_opcode_fetch;

	// Select one forces background, select zero tags the opcode
	always @*
	begin
		force_bgnd_d = 1'b0;
		tag_opcode_d = 1'b0;
		case (i_force_tag_select)
			1'b1:
				force_bgnd_d = force_hit;
			1'b0:
				tag_opcode_d = tag_hit;
			default:
			begin
				force_bgnd_d = 1'b0;
				tag_opcode_d = 1'b0;
			end
		endcase
	end

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_force_bgnd_req <= 1'b0;
			o_tag_opcode     <= 1'b0;
		end
		else
		begin
			o_force_bgnd_req <= force_bgnd_d;
			o_tag_opcode     <= tag_opcode_d;
		end
	end

	// ==========================================================
	// Force reset register

	// Writes from application code never reach the reset path
	assign frc_take = frc_request(i_frc_wr, i_frc_wr_serial,
		i_frc_wdata);

	// The register has no storage; every read returns zero
	always @*
	begin
		frc_rdata_d  = `DBKFR_FRC_READ;
		frc_rvalid_d = i_frc_rd;
	end

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_frc_rdata  <= `DBKFR_FRC_READ;
			o_frc_rvalid <= 1'b0;
		end
		else
		begin
			o_frc_rdata  <= frc_rdata_d;
			o_frc_rvalid <= frc_rvalid_d;
		end
	end

	// ==========================================================
	// Device reset request

	// Stretch the one-cycle request so the system reset sees it;
	// a new request during the pulse restarts it
	dbkfr_reset_pulse u_pulse
	(
		.i_sys_clk   (i_sys_clk),
		.i_rst_n     (i_rst_n),
		.i_trigger   (frc_take),
		.o_reset_req (rst_req)
	);

	always @*
	begin
		device_reset_d = rst_req;
	end

	// Registered so the output comes straight from a flip-flop
	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			o_device_reset_req <= 1'b0;
		else
			o_device_reset_req <= device_reset_d;
	end
endmodule

// ==== dbkfr_sva.sv ====
// Checker
`timescale 1ns/1ps
module dbkfr_sva(input wire i_sys_clk,i_rst_n,i_frc_wr,i_frc_wr_serial,
	o_device_reset_req,i_read_breakpoint_command,o_bkpt_rvalid,i_frc_rd,
	o_frc_rvalid,i_breakpoint_enable,i_force_tag_select,i_cpu_addr_valid,
	i_opcode_fetch,o_force_bgnd_req,o_tag_opcode,
	input wire [7:0] i_frc_wdata,o_frc_rdata);
default clocking @(posedge i_sys_clk); endclocking
default disable iff(!i_rst_n);
wire go=i_frc_wr&i_frc_wr_serial&i_frc_wdata[0];
property p_fr; go|=>##1 o_device_reset_req[*4]; endproperty
a_fr: assert property(p_fr) else $error("reset pulse too short");
property p_ap; $rose(o_device_reset_req)|->$past(go,2); endproperty
a_ap: assert property(p_ap) else $error("reset without serial write");
property p_brd; i_read_breakpoint_command|=>o_bkpt_rvalid; endproperty
a_brd: assert property(p_brd) else $error("no breakpoint read");
property p_frd; i_frc_rd|=>o_frc_rvalid&&o_frc_rdata==8'h00; endproperty
a_frd: assert property(p_frd) else $error("force read not zero");
property p_off;
	!i_breakpoint_enable|=>!o_force_bgnd_req&&!o_tag_opcode;
endproperty
a_off: assert property(p_off) else $error("breakpoint while off");
property p_fb;
	o_force_bgnd_req|->$past(i_breakpoint_enable&&i_force_tag_select&&
		i_cpu_addr_valid);
endproperty
a_fb: assert property(p_fb) else $error("bad force request");
property p_tg;
	o_tag_opcode|->$past(i_breakpoint_enable&&!i_force_tag_select&&
		i_cpu_addr_valid&&i_opcode_fetch);
endproperty
a_tg: assert property(p_tg) else $error("bad opcode tag");
cover property(go);
cover property(i_frc_wr);
cover property(o_device_reset_req);
endmodule
bind dbkfr_top dbkfr_sva u_sva(.*);

// ==== tb_top.sv ====
// Bench
`timescale 1ns/1ps
module tb_top;
reg c=0,r=0,w=0,q=0,f=0,s=0,d=0,e=0,t=0;
reg [7:0] x=0;
wire [15:0] o;
wire [7:0] z;
wire zv,g,h,y,bv;
integer failures=0,num_checks=0,k;
dbkfr_top dut(.i_sys_clk(c),.i_rst_n(r),.i_write_breakpoint_command(w),
.i_read_breakpoint_command(q),.i_bkpt_wdata(16'ha5c3),.i_frc_wr(f),
.i_frc_wr_serial(s),.i_frc_rd(d),.i_frc_wdata(x),.i_breakpoint_enable(e),
.i_force_tag_select(t),.i_cpu_addr(16'ha5c3),.i_cpu_addr_valid(1'b1),
.i_opcode_fetch(1'b1),.o_bkpt_rdata(o),.o_bkpt_rvalid(bv),.o_frc_rdata(z),
.o_frc_rvalid(zv),.o_force_bgnd_req(g),.o_tag_opcode(h),
.o_device_reset_req(y));
initial forever #10 c=~c;
initial begin #99999 failures=failures+1; report_and_stop; end
task ck(input [15:0] a,m);
num_checks=num_checks+1;
if(a!==m) begin failures=failures+1;
$display("unexpected %0t %h %h",$time,a,m); end
endtask
task report_and_stop;
if(failures==0&&num_checks>0)
$display("All tests passed");
else
$display("Some tests failed");
$finish;
endtask
initial begin repeat(12) @(posedge c); r<=1; @(posedge c) q<=1;
@(posedge c) q<=0; #1 ck(o,0);
@(posedge c) w<=1; @(posedge c) begin w<=0; q<=1; end
@(posedge c) q<=0; #1 ck(o,16'ha5c3); ck(bv,1);
for(k=0;k<3;k=k+1) begin @(posedge c) begin e<=k!=2; t<=k==0; end
@(posedge c) #1 ck({g,h},{k==0,k==1}); end
for(k=0;k<3;k=k+1) begin @(posedge c) begin f<=1; s<=k>0; x<=k!=1; end
@(posedge c) f<=0; @(posedge c) #1 ck(y,k==2); end
@(posedge c) d<=1; @(posedge c) d<=0; #1 ck({zv,z},16'h0100);
report_and_stop; end
endmodule
